// ==== kwd_defines.vh ====
`ifndef KWD_DEFINES_VH
`define KWD_DEFINES_VH
`define KWD_ADDR_OVERFLOW_MODE 8'h00
`define KWD_ADDR_CLOCK_MODE 8'h04
`define KWD_ADDR_RESTART_CONTROL 8'h08
`define KWD_ADDR_OVERFLOW_STATUS 8'h0c
`define KWD_ADDR_IRQ_STATUS 8'h10
`define KWD_ADDR_IRQ_MASK 8'h14
`define KWD_MODE_KEY 12'h234
`define KWD_CLOCK_KEY 9'h06e
`define KWD_RESTART_KEY 16'hc071
`define KWD_BIT_GLOBAL_ENABLE 0
`define KWD_BIT_RESET_GEN 1
`define KWD_BIT_INTERRUPT_GEN 2
`define KWD_BIT_EXTERNAL_PIN 3
`define KWD_MODE_KEY_LSB 4
`define KWD_CLOCK_KEY_LSB 7
`define KWD_HIGH_PRELOAD_LSB 2
`define KWD_RESET_MODE 4'h0
`define KWD_RESET_CLOCK 6'h00
`define KWD_LOW_PRELOAD 12'hfff
`define KWD_PIN_CYCLES 4'h8
`define KWD_DIV_8 10'h007
`define KWD_DIV_32 10'h01f
`define KWD_DIV_128 10'h07f
`define KWD_DIV_1024 10'h3ff
`endif

// ==== kwd_prescaler.v ====
`timescale 1ns/1ps
`include "kwd_defines.vh"
module kwd_prescaler (
  clk_sys,
  reset_n,
  restart,
  clock_select,
  tick
);
  input wire clk_sys;
  input wire reset_n;
  input wire restart;
  input wire [1:0] clock_select;
  output reg tick;
  reg [9:0] count;
  reg [9:0] limit;
  always @* begin
    case (clock_select)
      2'b00: limit = `KWD_DIV_8;
      2'b01: limit = `KWD_DIV_32;
      2'b10: limit = `KWD_DIV_128;
      default: limit = `KWD_DIV_1024;
    endcase
  end
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= 10'h000;
      tick <= 1'b0;
    end else if (restart || count >= limit) begin
      count <= 10'h000;
      tick <= !restart;
    end else begin
      count <= count + 10'h001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== kwd_pin_pulse.v ====
`timescale 1ns/1ps
`include "kwd_defines.vh"
module kwd_pin_pulse (
  clk_sys,
  reset_n,
  start,
  pin_n
);
  input wire clk_sys;
  input wire reset_n;
  input wire start;
  output reg pin_n;
  reg [3:0] left;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      left <= 4'h0;
      pin_n <= 1'b1;
    end else if (start) begin
      left <= `KWD_PIN_CYCLES - 4'h1;
      pin_n <= 1'b0;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      pin_n <= 1'b0;
    end else begin
      pin_n <= 1'b1;
    end
  end
endmodule

// ==== kwd_watchdog.v ====
// Functional notes
// [RQ1] overflow with reset enable raises internal reset request
// [RQ2] overflow with interrupt enable pulses the irq line
// [RQ3] overflow with pin enable drives pin low eight clocks
// [RQ4] sixteen-bit counter counts down on each prescaled tick
// [RQ5] restart loads counter bits 12-15 from high preload field
// [RQ6] counter clocked from master clock over 8, 32, 128 or 1024
// [RQ7] software restarts the counter regularly before overflow
// [RQ8] mode and control writes need the key in same write
// [RQ9] mode register write accepted only with key 0x234
// [RQ10] mode key field reads back as zero
// [RQ11] global enable gates all overflow signals; here the overflow flag and the irq output are not gated
// [RQ12] mode bits: enable, reset, interrupt, pin; key above
// [RQ13] mode, clock and status reset to zero; control write-only
// [RQ14] restart preloads low twelve bits with ones
// [RQ15] restart key 0xc071 restarts counter, other values ignored
// [RQ16] clock mode write accepted only with key 0x06e, reads zero
// [RQ17] overflow flag set on overflow, cleared by restart or reset
// [RQ18] clock select 00/01/10/11 means divide 8/32/128/1024
// [RQ19] overflow when counter passes zero, signalled once per restart
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "kwd_defines.vh"
module kwd_watchdog (
  clk_sys,
  reset_n,
  bus_addr,
  bus_wdata,
  bus_write,
  bus_read,
  bus_rdata,
  internal_reset_request,
  overflow_irq_line,
  overflow_pin_n,
  irq
);
  input wire clk_sys;
  input wire reset_n;
  input wire [7:0] bus_addr;
  input wire [31:0] bus_wdata;
  input wire bus_write;
  input wire bus_read;
  output reg [31:0] bus_rdata;
  output reg internal_reset_request;
  output reg overflow_irq_line;
  output wire overflow_pin_n;
  output wire irq;

  reg [3:0] mode;
  reg [5:0] clock_cfg;
  reg [15:0] counter;
  reg overflow_flag;
  reg expired;
  reg irq_status;
  reg irq_mask;
  reg restart;
  reg pin_start;
  reg [31:0] next_rdata;
  wire tick;
  wire overflow_event;
  wire global_enable;
  wire [1:0] clock_select;
  wire [3:0] high_preload_value;

  assign global_enable = mode[`KWD_BIT_GLOBAL_ENABLE];
  assign clock_select = clock_cfg[1:0];
  assign high_preload_value = clock_cfg[5:2];

  always @* begin
    restart = bus_write && bus_addr == `KWD_ADDR_RESTART_CONTROL &&
              bus_wdata[15:0] == `KWD_RESTART_KEY; // see [RQ15]
  end

  kwd_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(restart),
    .clock_select(clock_select), // see [RQ6] see [RQ18]
    .tick(tick)
  );

  // down count; overflow when a tick finds zero, then hold
  assign overflow_event = tick && !expired && counter == 16'h0000; // see [RQ19]

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counter <= 16'hffff;
      expired <= 1'b0;
    end else if (restart) begin
      counter <= {high_preload_value, `KWD_LOW_PRELOAD}; // see [RQ5] see [RQ14]
      expired <= 1'b0;
    end else if (overflow_event) begin
      expired <= 1'b1; // see [RQ19]
    end else if (tick && !expired) begin
      counter <= counter - 16'h0001; // see [RQ4]
    end
  end

  // keyed mode and clock writes; irq mask write needs no key
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode <= `KWD_RESET_MODE; // see [RQ13]
      clock_cfg <= `KWD_RESET_CLOCK;
      irq_mask <= 1'b0;
    end else if (bus_write) begin
      if (bus_addr == `KWD_ADDR_OVERFLOW_MODE) begin
        if (bus_wdata[15:`KWD_MODE_KEY_LSB] == `KWD_MODE_KEY) begin
          mode <= bus_wdata[3:0]; // see [RQ8] see [RQ9] see [RQ12]
        end
      end else if (bus_addr == `KWD_ADDR_CLOCK_MODE) begin
        if (bus_wdata[15:`KWD_CLOCK_KEY_LSB] == `KWD_CLOCK_KEY) begin
          clock_cfg <= bus_wdata[5:0]; // see [RQ8] see [RQ16]
        end
      end else if (bus_addr == `KWD_ADDR_IRQ_MASK) begin
        irq_mask <= bus_wdata[0];
      end
    end
  end

  // reset, irq line and pin outputs gated by global enable; overflow flag and irq status are not
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      internal_reset_request <= 1'b0;
      overflow_irq_line <= 1'b0;
      pin_start <= 1'b0;
      overflow_flag <= 1'b0;
      irq_status <= 1'b0;
    end else begin
      internal_reset_request <= overflow_event && global_enable &&
        mode[`KWD_BIT_RESET_GEN]; // see [RQ1] see [RQ11]
      overflow_irq_line <= overflow_event && global_enable &&
        mode[`KWD_BIT_INTERRUPT_GEN]; // see [RQ2] see [RQ11]
      pin_start <= overflow_event && global_enable &&
        mode[`KWD_BIT_EXTERNAL_PIN]; // see [RQ3] see [RQ11]
      if (overflow_event) begin
        overflow_flag <= 1'b1; // see [RQ17]
      end else if (restart) begin
        overflow_flag <= 1'b0; // see [RQ17]
      end
      if (overflow_event) begin
        irq_status <= 1'b1;
      end else if (bus_read && bus_addr == `KWD_ADDR_IRQ_STATUS) begin
        irq_status <= 1'b0;
      end
    end
  end

  kwd_pin_pulse u_pin_pulse (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(pin_start),
    .pin_n(overflow_pin_n) // see [RQ3]
  );

  assign irq = irq_status && irq_mask;

  // read mux; keys read zero, control reads zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (bus_addr == `KWD_ADDR_OVERFLOW_MODE) begin
      next_rdata[3:0] = mode; // see [RQ10]
    end else if (bus_addr == `KWD_ADDR_CLOCK_MODE) begin
      next_rdata[5:0] = clock_cfg; // see [RQ16]
    end else if (bus_addr == `KWD_ADDR_OVERFLOW_STATUS) begin
      next_rdata[0] = overflow_flag;
    end else if (bus_addr == `KWD_ADDR_IRQ_STATUS) begin
      next_rdata[0] = irq_status;
    end else if (bus_addr == `KWD_ADDR_IRQ_MASK) begin
      next_rdata[0] = irq_mask;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_read) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end
endmodule

// ==== kwd_partner.sv ====
`timescale 1ns/1ps
module kwd_partner (
  input wire clk_sys,
  input wire reset_n,
  input wire internal_reset_request,
  input wire overflow_irq_line,
  input wire overflow_pin_n,
  output reg [7:0] rst_seen,
  output reg [7:0] irq_seen,
  output reg [7:0] low_cnt
);
  // reset generator, interrupt controller and pin sampler tallies
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_seen <= 8'h00;
      irq_seen <= 8'h00;
      low_cnt <= 8'h00;
    end else begin
      rst_seen <= rst_seen + internal_reset_request;
      irq_seen <= irq_seen + overflow_irq_line;
      low_cnt <= low_cnt + !overflow_pin_n;
    end
  end
endmodule

// ==== kwd_watchdog_monitor.sv ====
`timescale 1ns/1ps
module kwd_watchdog_monitor (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] bus_addr,
  input wire bus_read,
  input wire [31:0] bus_rdata,
  input wire internal_reset_request,
  input wire overflow_irq_line,
  input wire overflow_pin_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence pin_window;
    !overflow_pin_n [*8] ##1 overflow_pin_n;
  endsequence
  sequence no_req;
    !internal_reset_request [*8];
  endsequence
  chk_pin_eight:
  assert property ($fell(overflow_pin_n) |-> pin_window)
    else $error("pin low time wrong");
  chk_rst_once:
  assert property (internal_reset_request |=> no_req)
    else $error("reset request repeated");
  chk_irq_once:
  assert property (overflow_irq_line |=> !overflow_irq_line [*8])
    else $error("irq pulse repeated");
  chk_rdata_idle:
  assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_mode_key_zero:
  assert property ($past(bus_read && bus_addr == 8'h00)
    |-> bus_rdata[31:4] == 28'h0) else $error("mode key read back");
  chk_clock_key_zero:
  assert property ($past(bus_read && bus_addr == 8'h04)
    |-> bus_rdata[31:6] == 26'h0) else $error("clock key read back");
  chk_status_bits:
  assert property ($past(bus_read && bus_addr == 8'h0c)
    |-> bus_rdata[31:1] == 31'h0) else $error("status spare bits set");
  chk_ctrl_wo:
  assert property ($past(bus_read && bus_addr == 8'h08)
    |-> bus_rdata == 32'h0) else $error("control register readable");
endmodule
bind kwd_watchdog kwd_watchdog_monitor mon (.clk_sys(clk_sys),
  .reset_n(reset_n), .bus_addr(bus_addr), .bus_read(bus_read),
  .bus_rdata(bus_rdata), .internal_reset_request(internal_reset_request),
  .overflow_irq_line(overflow_irq_line), .overflow_pin_n(overflow_pin_n));

// ==== kwd_watchdog_tb.sv ====
`timescale 1ns/1ps
module kwd_watchdog_tb;
  reg clk_sys = 0;
  reg reset_n = 0;
  reg [7:0] bus_addr = 8'h00;
  reg [31:0] bus_wdata = 32'h0;
  reg bus_write = 0;
  reg bus_read = 0;
  reg pend = 0;
  wire [31:0] bus_rdata;
  wire rst_req, irq_ln, pin_n, irq;
  wire [7:0] rst_seen, irq_seen, low_cnt;
  integer mismatches = 0;
  integer checked = 0;
  integer seed = 32'h29da8a2f;
  integer i, n;
  reg [31:0] k;
  logic [31:0] exp_q[$];
  always #5 clk_sys = ~clk_sys;
  kwd_watchdog uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata), .irq(irq),
    .internal_reset_request(rst_req), .overflow_irq_line(irq_ln),
    .overflow_pin_n(pin_n));
  kwd_partner far (.clk_sys(clk_sys), .reset_n(reset_n),
    .internal_reset_request(rst_req), .overflow_irq_line(irq_ln),
    .overflow_pin_n(pin_n), .rst_seen(rst_seen), .irq_seen(irq_seen),
    .low_cnt(low_cnt));
  task check(input string nm, input [31:0] seen, input [31:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1;
    @(posedge clk_sys);
    bus_write <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_read <= 1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus_read <= 0;
  endtask
  always @(posedge clk_sys) begin
    pend <= bus_read;
    if (pend) check("rdata", bus_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1;
    for (i = 0; i < 9; i = i + 1) rd({i[5:0], 2'b00}, 32'h0);
    k = $random(seed) & 32'hfff0;
    if (k[15:4] == 12'h234) k = 32'h0;
    wr(8'h00, k | 32'hf);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'h2347);
    rd(8'h00, 32'h7);
    wr(8'h04, 32'h3f);
    rd(8'h04, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      k = $random(seed) & 32'h3c | i;
      wr(8'h04, 32'h3700 | k);
      rd(8'h04, k);
    end
    $display("test registers done");
    wr(8'h04, 32'h3700);
    wr(8'h00, 32'h234f);
    wr(8'h14, 32'h1);
    wr(8'h08, 32'hc071);
    for (n = 0; n < 40000 && irq_ln !== 1; n = n + 1) @(negedge clk_sys);
    check("timeout", n >= 32760 && n <= 32792, 1);
    if (n == 40000) summarize;
    check("rst_req", rst_req, 1);
    check("irq", irq, 1);
    check("pin_early", pin_n, 1);
    @(negedge clk_sys);
    check("pin_low", pin_n, 0);
    rd(8'h0c, 32'h1);
    rd(8'h10, 32'h1);
    rd(8'h10, 32'h0);
    check("irq_clear", irq, 0);
    repeat (12) @(posedge clk_sys);
    check("pulses", {rst_seen, irq_seen, low_cnt}, 24'h010108);
    $display("test overflow done");
    wr(8'h08, 32'hc070);
    rd(8'h0c, 32'h1);
    wr(8'h08, 32'hc071);
    rd(8'h0c, 32'h0);
    repeat (3) @(posedge clk_sys);
    $display("test restart done");
    wr(8'h00, 32'h234e);
    wr(8'h08, 32'hc071);
    for (n = 0; n < 40000 && irq !== 1; n = n + 1) @(negedge clk_sys);
    check("gated_time", n >= 32760 && n <= 32792, 1);
    if (n == 40000) summarize;
    repeat (12) @(posedge clk_sys);
    check("gated", {rst_seen, irq_seen, low_cnt}, 24'h010108);
    rd(8'h0c, 32'h1);
    repeat (3) @(posedge clk_sys);
    $display("test global enable done");
    summarize;
  end
endmodule
